// ### verilog/msc_defines.vh
// Purpose: constants of the module sideband control block
// Assumes: 250 MHz core clock
// Notes: map offsets index the byte pointer of the 2-wire slave
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

`define MSC_CLK_PERIOD_NS 4
`define MSC_SLAVE_ADDR 7'h50
// reset pin low time before a module reset starts
`define MSC_RST_MIN_NS 2000
`define MSC_RST_MIN_CYC ((`MSC_RST_MIN_NS+`MSC_CLK_PERIOD_NS-1)/`MSC_CLK_PERIOD_NS)
// internal initialisation time after any reset
`define MSC_INIT_NS 1000
`define MSC_INIT_CYC (`MSC_INIT_NS/`MSC_CLK_PERIOD_NS)

`define MSC_OFS_STATUS 8'h00
`define MSC_OFS_FLAGS 8'h01
`define MSC_OFS_MASK 8'h02
`define MSC_OFS_CTRL 8'h03

`define MSC_ST_DNR 0
`define MSC_ST_ATT 1
`define MSC_ST_LP 2
`define MSC_FL_DONE 0
`define MSC_FL_FAULT 1
`define MSC_FL_CRIT 2
`define MSC_CTRL_FORCE_LP 0

`define MSC_MASK_RST 3'h7
`define MSC_CTRL_RST 1'h0
`define MSC_SYNC_RST 5'h1f

`endif

// ### verilog/msc_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk_in
// Notes: the first stage feeds only the second stage
module msc_sync #(
   parameter W = 5,
   parameter [W-1:0] INIT = {W{1'b1}}
) (
   input wire clk_in,
   input wire srst_in,
   input wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);

reg [W-1:0] stage1;
reg [W-1:0] stage2;

genvar i;
generate
   for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_in) begin
         if (srst_in) begin
            stage1[i] <= INIT[i];
            stage2[i] <= INIT[i];
         end else begin
            stage1[i] <= d_in[i];
            stage2[i] <= stage1[i];
         end
      end
   end
endgenerate

assign q_out = stage2;

endmodule // msc_sync

// ### verilog/msc_sideband.v
// Purpose: sideband pins and 2-wire management slave of a pluggable module
// Assumes: one 250 MHz clock; scl and sda oversampled through synchronisers
// Notes: sda and attention are open drain, enable high pulls the pin low
`include "msc_defines.vh"

//////////////////////////////////////////////////////////////////////////////
module msc_sideband (
   input wire clk_in,
   input wire srst_in,
   input wire bus_select_n_in,
   input wire module_reset_n_in,
   input wire low_power_select_in,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   output reg presence_n_out,
   output reg attention_n_out,
   output reg attention_oe_out,
   output reg high_power_en_out,
   output reg not_ready_out,
   input wire fault_in,
   input wire critical_in
);

localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_ADDR = 6'h02;
localparam [5:0] ST_WDATA = 6'h04;
localparam [5:0] ST_ACK = 6'h08;
localparam [5:0] ST_RDATA = 6'h10;
localparam [5:0] ST_ACK_R = 6'h20;
localparam integer RST_MIN_INT = `MSC_RST_MIN_CYC;
localparam integer INIT_LAST_INT = `MSC_INIT_CYC - 1;
localparam [11:0] RST_MIN_CYC = RST_MIN_INT[11:0];
localparam [11:0] INIT_LAST = INIT_LAST_INT[11:0];
function [7:0] map_read;
   input [7:0] ofs;
   input [2:0] status;
   input [2:0] flags;
   input [2:0] mask;
   input ctrl;
   begin
      case (ofs)
         `MSC_OFS_STATUS: map_read = {5'h00, status};
         `MSC_OFS_FLAGS: map_read = {5'h00, flags};
         `MSC_OFS_MASK: map_read = {5'h00, mask};
         `MSC_OFS_CTRL: map_read = {7'h00, ctrl};
         default: map_read = 8'h00;
      endcase
   end
endfunction

//////////////////////////////////////////////////////////////////////////////
// pin synchronisers
wire [4:0] sync_q;
wire scl_s = sync_q[4];
wire sda_s = sync_q[3];
wire sel_n_s = sync_q[2];
wire rst_n_s = sync_q[1];
wire lp_s = sync_q[0];
msc_sync #(.W(5), .INIT(`MSC_SYNC_RST)) u_sync (
   .clk_in(clk_in),
   .srst_in(srst_in),
   .d_in({scl_in, sda_in, bus_select_n_in, module_reset_n_in,
      low_power_select_in}),
   .q_out(sync_q)
);

//////////////////////////////////////////////////////////////////////////////
// reset pin filter and initialisation
reg [11:0] low_cnt;
reg [11:0] init_cnt;
reg dnr;
wire pin_reset = (low_cnt == RST_MIN_CYC);
wire core_rst = srst_in | pin_reset;
wire init_done = dnr & (init_cnt == INIT_LAST);

always @(posedge clk_in) begin
   if (srst_in | rst_n_s) begin
      low_cnt <= 12'h000;
   end else if (low_cnt != RST_MIN_CYC) begin
      low_cnt <= low_cnt + 12'h001;
   end
end

// power-up also runs through here, so completion posts unprompted
always @(posedge clk_in) begin
   if (core_rst) begin
      dnr <= 1'b1;
      init_cnt <= 12'h000;
   end else if (dnr) begin
      if (init_done) begin
         dnr <= 1'b0;
      end else begin
         init_cnt <= init_cnt + 12'h001;
      end
   end
end

//////////////////////////////////////////////////////////////////////////////
// 2-wire slave
reg [5:0] state;
reg scl_d;
reg sda_d;
reg [3:0] bit_cnt;
reg [7:0] shift;
reg [7:0] tx;
reg [7:0] ptr;
reg rw;
reg first;
reg [2:0] mask;
reg ctrl_lp;
reg [2:0] flags;
reg rd_clr;
reg [2:0] clr_bits;

wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_c = scl_s & scl_d & sda_d & ~sda_s;
wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
wire lp_active = lp_s | ctrl_lp;
wire [2:0] status = {lp_active, attention_oe_out, dnr};
wire [7:0] rd_byte = map_read(ptr, status, flags, mask, ctrl_lp);

always @(posedge clk_in) begin
   if (srst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
   end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
   end
end

always @(posedge clk_in) begin
   if (core_rst) begin
      state <= ST_IDLE;
      sda_oe_out <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      mask <= `MSC_MASK_RST;
      ctrl_lp <= `MSC_CTRL_RST;
      rd_clr <= 1'b0;
      clr_bits <= 3'h0;
   end else begin
      rd_clr <= 1'b0;
      if (sel_n_s) begin
         state <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else if (start_c) begin
         state <= ST_ADDR;
         bit_cnt <= 4'h0;
         sda_oe_out <= 1'b0;
         first <= 1'b1;
      end else if (stop_c) begin
         state <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               sda_oe_out <= 1'b0;
            end
            ST_ADDR, ST_WDATA: begin
               if (scl_rise) begin
                  shift <= {shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (state == ST_ADDR) begin
                     if (shift[7:1] == `MSC_SLAVE_ADDR) begin
                        rw <= shift[0];
                        sda_oe_out <= 1'b1;
                        state <= ST_ACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     sda_oe_out <= 1'b1;
                     state <= ST_ACK;
                     if (first) begin
                        ptr <= shift;
                        first <= 1'b0;
                     end else begin
                        ptr <= ptr + 8'h01;
                        if (ptr == `MSC_OFS_MASK) begin
                           mask <= shift[2:0];
                        end
                        if (ptr == `MSC_OFS_CTRL) begin
                           ctrl_lp <= shift[`MSC_CTRL_FORCE_LP];
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (rw) begin
                     tx <= rd_byte;
                     sda_oe_out <= ~rd_byte[7];
                     ptr <= ptr + 8'h01;
                     state <= ST_RDATA;
                     if (ptr == `MSC_OFS_FLAGS) begin
                        rd_clr <= 1'b1;
                        clr_bits <= rd_byte[2:0];
                     end
                  end else begin
                     sda_oe_out <= 1'b0;
                     state <= ST_WDATA;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     sda_oe_out <= 1'b0;
                     bit_cnt <= 4'h0;
                     state <= ST_ACK_R;
                  end else begin
                     tx <= {tx[6:0], 1'b0};
                     sda_oe_out <= ~tx[6];
                  end
               end
            end
            ST_ACK_R: begin
               if (scl_rise) begin
                  state <= sda_s ? ST_IDLE : ST_ACK;
               end
            end
            default: begin
               state <= ST_IDLE;
               sda_oe_out <= 1'b0;
            end
         endcase
      end
   end
end

//////////////////////////////////////////////////////////////////////////////
// event flags, attention and power
wire [2:0] flag_set = {critical_in, fault_in, init_done};
wire [2:0] flag_clr = rd_clr ? clr_bits : 3'h0;

// set beats a clear-on-read in the same cycle
always @(posedge clk_in) begin
   if (core_rst) begin
      flags <= 3'h0;
   end else begin
      flags <= (flags & ~flag_clr) | flag_set;
   end
end

always @(posedge clk_in) begin
   if (core_rst) begin
      attention_oe_out <= 1'b0;
      high_power_en_out <= 1'b0;
      not_ready_out <= 1'b1;
   end else begin
      attention_oe_out <= |(flags & mask);
      high_power_en_out <= ~lp_active;
      not_ready_out <= dnr;
   end
end

// open-drain levels are always low; only the enables move
always @(posedge clk_in) begin
   if (srst_in) begin
      sda_out <= 1'b0;
      attention_n_out <= 1'b0;
      presence_n_out <= 1'b0;
   end else begin
      sda_out <= 1'b0;
      attention_n_out <= 1'b0;
      presence_n_out <= 1'b0;
   end
end

endmodule // msc_sideband

// ### testbench/msc_sideband_properties.sv
// Purpose: port checks of msc_sideband
// Assumes: bench keeps mask bits 0 and 1 set
// Notes: bound to every msc_sideband instance
module msc_sideband_properties (
   input wire clk_in,
   input wire srst_in,
   input wire bus_select_n_in,
   input wire module_reset_n_in,
   input wire low_power_select_in,
   input wire fault_in,
   input wire sda_out,
   input wire sda_oe_out,
   input wire presence_n_out,
   input wire attention_n_out,
   input wire attention_oe_out,
   input wire high_power_en_out,
   input wire not_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   logic [15:0] nr_cnt;
   logic [15:0] low_cnt;
   /////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      if (srst_in || !not_ready_out) nr_cnt <= 16'h0;
      else nr_cnt <= nr_cnt + 16'h1;
   end
   always @(posedge clk_in) begin
      if (srst_in || module_reset_n_in) low_cnt <= 16'h0;
      else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h1;
   end
   /////////////////////////////////////////////////////////////////////
   a_presence_ground: assert property (presence_n_out == 1'b0)
      else $error("presence not grounded");
   a_att_pull_only: assert property (attention_n_out == 1'b0)
      else $error("attention drives high");
   a_sda_pull_only: assert property (sda_out == 1'b0)
      else $error("sda drives high");
   a_select_quiet: assert property (bus_select_n_in [*4] |-> !sda_oe_out)
      else $error("sda driven while deselected");
   a_power_limit: assert property
      (low_power_select_in [*4] |-> !high_power_en_out)
      else $error("high power in low power mode");
   a_init_length: assert property ($fell(not_ready_out) |-> nr_cnt >= 16'd248)
      else $error("not ready too short");
   a_short_pulse: assert property ($rose(not_ready_out) |-> low_cnt >= 16'd500)
      else $error("reset started early");
   a_long_pulse: assert property (low_cnt == 16'd520 |-> not_ready_out)
      else $error("long reset pulse ignored");
   a_done_attention: assert property
      ($fell(not_ready_out) |-> ##[0:3] attention_oe_out)
      else $error("no completion attention");
   a_fault_attention: assert property
      (fault_in && module_reset_n_in |-> ##[1:4] attention_oe_out)
      else $error("fault not signalled");
   cover property ($fell(not_ready_out));
   cover property ($rose(not_ready_out));
   cover property ($rose(sda_oe_out));
endmodule // msc_sideband_properties

bind msc_sideband msc_sideband_properties chk_u (.clk_in, .srst_in,
   .bus_select_n_in, .module_reset_n_in, .low_power_select_in, .fault_in,
   .sda_out, .sda_oe_out, .presence_n_out, .attention_n_out,
   .attention_oe_out, .high_power_en_out, .not_ready_out);

// ### testbench/msc_host_model.sv
// Purpose: host side 2-wire master with a pull-up on sda
// Assumes: hp step of 10 clocks, three steps per scl bit
// Notes: tasks are called by the bench
module msc_host_model (
   input wire clk_in,
   input wire sda_oe_in,
   output logic scl_out,
   output wire sda_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv_low = 1'b0;
   initial scl_out = 1'b1;
   // pull-up resolves the open-drain wire
   assign sda_out = ~(drv_low | sda_oe_in);
   task automatic hp;
      repeat (10) @(posedge clk_in);
   endtask
   task automatic start;
      drv_low <= 1'b1;
      hp;
   endtask
   task automatic put(input logic b);
      scl_out <= 1'b0;
      hp;
      drv_low <= ~b;
      hp;
      scl_out <= 1'b1;
      hp;
   endtask
   task automatic get(output logic b);
      scl_out <= 1'b0;
      drv_low <= 1'b0;
      hp;
      scl_out <= 1'b1;
      hp;
      b = sda_out;
      hp;
   endtask
   task automatic stop;
      put(1'b0);
      drv_low <= 1'b0;
      hp;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) put(d[i]);
      get(a);
      ack = ~a;
   endtask
   task automatic rbyte(output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(1'b1);
   endtask
endmodule // msc_host_model

// ### testbench/msc_sideband_tb_top.sv
// Purpose: self-checking bench of msc_sideband
// Assumes: host model drives the 2-wire bus
// Notes: one select line for this module only
module msc_sideband_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, srst_in = 1, sel_n = 1, rst_n = 1;
   logic lp = 0, fault = 0, crit = 0, a;
   logic [7:0] d;
   logic [31:0] seed = 32'hfad45e42;
   logic [31:0] r;
   wire scl, sda, sda_o, sda_oe, pres_n, att_n, att_oe, hp_en, nr;
   int n_mismatch = 0, total_checks = 0;
   initial forever #2 clk_in = ~clk_in;
   msc_sideband dut_u (.clk_in(clk_in), .srst_in(srst_in),
      .bus_select_n_in(sel_n), .module_reset_n_in(rst_n),
      .low_power_select_in(lp), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .presence_n_out(pres_n),
      .attention_n_out(att_n), .attention_oe_out(att_oe),
      .high_power_en_out(hp_en), .not_ready_out(nr),
      .fault_in(fault), .critical_in(crit));
   msc_host_model h (.clk_in(clk_in), .sda_oe_in(sda_oe),
      .scl_out(scl), .sda_out(sda));
   /////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] exp_flags(input logic [31:0] v);
      return {5'h00, v[2], v[1], 1'b0};
   endfunction
   function automatic logic [7:0] exp_att(input logic [31:0] v,
      input logic [2:0] m);
      return {7'h00, |({v[2], v[1]} & m[2:1])};
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic addr(input logic [7:0] b);
      h.start;
      h.wbyte(b, a);
      chk("ack", a, 1);
   endtask
   task automatic wr(input logic [7:0] o, v);
      addr(8'ha0);
      h.wbyte(o, a);
      h.wbyte(v, a);
      h.stop;
   endtask
   task automatic rd(input logic [7:0] o, output logic [7:0] v);
      addr(8'ha0);
      h.wbyte(o, a);
      h.stop;
      addr(8'ha1);
      h.rbyte(v);
      h.stop;
   endtask
   /////////////////////////////////////////////////////////////////////
   initial begin
      cyc(5);
      srst_in <= 1'b0;
      sel_n <= 1'b0;
      cyc(3);
      chk("not_ready", nr, 1);
      cyc(300);
      chk("not_ready", nr, 0);
      chk("attention", att_oe, 1);
      chk("presence", pres_n, 0);
      rd(8'h01, d);
      chk("flags", d, 8'h01);
      rd(8'h00, d);
      chk("status", d, 8'h00);
      wr(8'h02, 8'h03);
      rd(8'h02, d);
      chk("mask", d, 8'h03);
      rd(8'h09, d);
      chk("unmapped", d, 8'h00);
      for (int k = 0; k < 8; k++) begin
         r = xs();
         lp <= r[0];
         fault <= r[1];
         crit <= r[2];
         cyc(1);
         fault <= 1'b0;
         crit <= 1'b0;
         cyc(8);
         chk("attention", att_oe, exp_att(r, 3'h3));
         chk("high_power", hp_en, {7'h0, ~r[0]});
         rd(8'h01, d);
         chk("flags", d, exp_flags(r));
      end
      h.start;
      h.wbyte(8'h84, a);
      h.stop;
      chk("ack", a, 0);
      lp <= 1'b0;
      wr(8'h03, 8'h01);
      chk("high_power", hp_en, 0);
      rd(8'h03, d);
      chk("ctrl", d, 8'h01);
      rd(8'h00, d);
      chk("status_lp", d & 8'h04, 8'h04);
      sel_n <= 1'b1;
      cyc(4);
      h.start;
      h.wbyte(8'ha0, a);
      h.stop;
      chk("ack", a, 0);
      sel_n <= 1'b0;
      rst_n <= 1'b0;
      cyc(100);
      rst_n <= 1'b1;
      cyc(5);
      chk("not_ready", nr, 0);
      rst_n <= 1'b0;
      cyc(520);
      chk("not_ready", nr, 1);
      rst_n <= 1'b1;
      cyc(300);
      chk("not_ready", nr, 0);
      chk("attention", att_oe, 1);
      chk("high_power", hp_en, 1);
      rd(8'h02, d);
      chk("mask", d, 8'h07);
      rd(8'h03, d);
      chk("ctrl", d, 8'h00);
      conclude;
   end
   initial begin
      cyc(60000);
      n_mismatch++;
      conclude;
   end
endmodule // msc_sideband_tb_top
